//--- rtl/adc_burst_accumulate_control.v
// Converter sequencer with burst accumulation and result formatting
`timescale 1ns/100ps
`default_nettype none
`include "adc_burst_defines.vh"

module adc_burst_accumulate_control #(
  parameter SAR_DIV = 4,
  parameter BURST_DIV = 2
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata_q,
  // Trigger sources
  input wire internal_trigger,
  input wire external_convert_pin,
  // Analog converter core
  input wire [9:0] core_code,
  output wire core_power,
  output wire core_track,
  output wire core_convert,
  output wire core_eight_bit,
  // Result towards window comparison
  output reg [7:0] result_high_byte_q,
  output reg [7:0] result_low_byte_q,
  output reg result_valid_q,
  // Status
  output wire conversion_complete_flag,
  output wire conversion_busy_bit
);

  // Register map, all registers eight bits wide and reset to zero
  //   control: enable, burst, complete flag, busy, two spare bits, trigger select
  //   config: tracking delay, eight-bit mode, justify/shift field, repeat field
  //   timing: power-up delay in the high nibble, burst tracking in the low nibble
  //   result high and result low are read only; writes to them are dropped
  //   unmapped reads return zero and unmapped writes are dropped
  //
  // Complete flag
  //   Writing zero to its control bit clears it; writing one leaves it alone
  //   A series ending in the same cycle as a clear keeps the flag set
  //
  // Busy bit
  //   Reads one whenever the sequencer is out of idle
  //   Writing one is a software start, honoured only under software trigger
  //
  // Trigger select
  //   0 software, 1 internal pulse, 2 external pin rising edge, 3 no source
  //   Selecting 3 parks the sequencer, handy while fields are reprogrammed
  //
  // Repeat field
  //   0 one sample, 1 four, 2 eight, 3 sixteen, 4 thirty-two, 5 sixty-four
  //   6 and 7 also give sixty-four rather than an undefined count
  //
  // Justify/shift field
  //   Low two bits shift the sum right by zero to three places
  //   Value 100 left-aligns a single ten-bit code in the result bytes, except in eight-bit mode
  //   Other codes with the top bit set behave as their low two bits
  //   Left alignment only suits one sample; software keeps it off for sums
  //
  // Power-up delay
  //   Counted in burst oscillator ticks: field value plus one ticks in all
  //   The extra tick covers the partial tick in which the start arrives
  //
  // Burst tracking
  //   Counted in burst oscillator ticks, zero to fifteen
  //   Applied before every burst sample except the first
  //
  // Tracking delay bit
  //   Adds four SAR ticks of tracking after a software or internal start
  //   Outside burst mode under the external pin the pin itself times tracking, so none are added
  //   In burst mode the four ticks are added to every sample
  //
  // Eight-bit mode
  //   A conversion takes ten SAR ticks instead of twelve
  //   The two dropped bits enter the sum as zero; the low result byte reads zero
  //
  // Clock enables
  //   Both slower rates come from free-running dividers of the one clock
  //   A conversion starts on an arbitrary divider phase, so its first tick
  //   may be up to one divider period short; later ticks are full length
  //
  // Trigger rate
  //   In burst mode sources keep starts at least four clocks apart
  //   Any start that arrives outside idle is dropped, not queued
  //
  // Core handshake
  //   core_convert stands high for the whole conversion
  //   core_code is taken at the clock edge that ends the last tick
  //   core_track is high while the sample capacitor should follow the input
  //
  // Result path
  //   The first sample of each series overwrites the accumulator
  //   Result bytes and the valid pulse change only at the end of a series
  //   result_valid_q is the strobe towards the window comparison
  //   The sum is sixteen bits; sixty-four full-scale samples still fit
  //
  // Reset
  //   All registers zero, converter unpowered, sequencer idle
  //   The external pin edge detector resets to the pin's idle low level,
  //   so releasing reset fakes a rising edge only if the pin is already high

  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_PWRUP = 4'b0010;
  localparam [3:0] S_TRACK = 4'b0100;
  localparam [3:0] S_CONV = 4'b1000;

  // Repeat field: 0..5 give 1,4,8,16,32,64; 6 and 7 also give 64
  function [6:0] repeat_count;
    input [2:0] f;
    begin
      case (f)
        3'h0: repeat_count = 7'h01;
        3'h1: repeat_count = 7'h04;
        3'h2: repeat_count = 7'h08;
        3'h3: repeat_count = 7'h10;
        3'h4: repeat_count = 7'h20;
        default: repeat_count = 7'h40;
      endcase
    end
  endfunction

  reg [7:0] control_q;
  reg [7:0] config_q;
  reg [7:0] timing_q;
  reg [3:0] state_q;
  reg power_q;
  reg done_q;
  reg pin_prev_q;
  reg [7:0] sar_div_q;
  reg [7:0] burst_div_q;
  reg [3:0] tk_rem_q;
  reg [2:0] sar_rem_q;
  reg [4:0] pw_rem_q;
  reg [3:0] conv_rem_q;
  reg [6:0] sample_cnt_q;
  reg [15:0] acc_q;

  wire enable_bit = control_q[`CTL_ENABLE];
  wire burst_bit = control_q[`CTL_BURST];
  wire [1:0] trig_sel = control_q[`CTL_TRIG_HI:`CTL_TRIG_LO];
  wire tracking_delay_bit = config_q[`CFG_TRACK_DELAY];
  wire eight_bit_mode_bit = config_q[`CFG_EIGHT_BIT];
  wire [2:0] justify_shift_field = config_q[`CFG_JUST_HI:`CFG_JUST_LO];
  wire [2:0] repeat_count_field = config_q[`CFG_RPT_HI:`CFG_RPT_LO];
  wire [3:0] powerup_delay_field = timing_q[`TIM_PWR_HI:`TIM_PWR_LO];
  wire [3:0] burst_tracking_field = timing_q[`TIM_TRK_HI:`TIM_TRK_LO];
  wire [6:0] rpt = repeat_count(repeat_count_field);

  wire sel_ctrl = reg_addr == `OFS_CONTROL;
  wire wr_ctrl = reg_write && sel_ctrl;
  wire wr_cfg = reg_write && (reg_addr == `OFS_CONFIG);
  wire wr_tim = reg_write && (reg_addr == `OFS_TIMING);

  wire sar_tick = sar_div_q == 8'h00;
  wire burst_tick = burst_div_q == 8'h00;
  wire ext_sel = trig_sel == `TRIG_EXTERNAL;
  wire pin_rise = external_convert_pin && !pin_prev_q;

  // Start sources, one of which is armed by the trigger select
  wire sw_start = wr_ctrl && reg_wdata[`CTL_BUSY] && trig_sel == `TRIG_SOFTWARE;
  wire hw_start = internal_trigger && trig_sel == `TRIG_INTERNAL;
  wire pin_start = pin_rise && ext_sel;
  wire start_any = sw_start || hw_start || pin_start;
  // Non-burst conversions need a powered converter; starts outside idle are dropped
  wire start_ok = start_any && state_q[0] && (burst_bit || enable_bit);

  // Sample with two forced-zero LSBs in eight-bit mode
  wire [9:0] sample = eight_bit_mode_bit ? {core_code[9:2], 2'b00} : core_code;
  wire first_sample = sample_cnt_q == 7'h00;
  wire [15:0] acc_sum = (first_sample ? 16'h0000 : acc_q) + {6'h00, sample};
  wire last_sample = (sample_cnt_q + 7'h01) >= rpt;
  wire conv_end = state_q[3] && sar_tick && conv_rem_q == 4'h1;
  wire [3:0] conv_len = eight_bit_mode_bit ? `CONV_TICKS_8 : `CONV_TICKS_10;

  // Formatting of the finished sum
  reg [15:0] formatted;
  always @* begin
    formatted = acc_sum >> justify_shift_field[1:0];
    if (justify_shift_field == `JUST_LEFT)
      formatted = {acc_sum[9:0], 6'h00};
    if (eight_bit_mode_bit)
      formatted = {formatted[9:2], 8'h00};
  end

  // SAR and burst clock enables
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sar_div_q <= 8'h00;
      burst_div_q <= 8'h00;
      pin_prev_q <= 1'b0;
    end else begin
      sar_div_q <= sar_tick ? SAR_DIV[7:0] - 8'h01 : sar_div_q - 8'h01;
      burst_div_q <= burst_tick ? BURST_DIV[7:0] - 8'h01 : burst_div_q - 8'h01;
      pin_prev_q <= external_convert_pin;
    end
  end

  // Register file
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control_q <= `CONTROL_RESET;
      config_q <= `CONFIG_RESET;
      timing_q <= `TIMING_RESET;
    end else begin
      if (wr_ctrl) begin
        control_q[`CTL_ENABLE] <= reg_wdata[`CTL_ENABLE];
        control_q[`CTL_BURST] <= reg_wdata[`CTL_BURST];
        control_q[`CTL_TRIG_HI:`CTL_TRIG_LO] <= reg_wdata[`CTL_TRIG_HI:`CTL_TRIG_LO];
      end
      if (wr_cfg)
        config_q <= reg_wdata;
      if (wr_tim)
        timing_q <= reg_wdata;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `OFS_CONTROL: reg_rdata_q <= {enable_bit, burst_bit, done_q, conversion_busy_bit,
                                      2'b00, trig_sel};
        `OFS_CONFIG: reg_rdata_q <= config_q;
        `OFS_TIMING: reg_rdata_q <= timing_q;
        `OFS_RESULT_HIGH: reg_rdata_q <= result_high_byte_q;
        `OFS_RESULT_LOW: reg_rdata_q <= result_low_byte_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // Complete flag: a set in the same cycle as a software clear wins
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      done_q <= 1'b0;
    else if (conv_end && last_sample)
      done_q <= 1'b1;
    else if (wr_ctrl && !reg_wdata[`CTL_DONE])
      done_q <= 1'b0;
  end

  // Sequencer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      power_q <= 1'b0;
      tk_rem_q <= 4'h0;
      sar_rem_q <= 3'h0;
      pw_rem_q <= 5'h00;
      conv_rem_q <= 4'h0;
      sample_cnt_q <= 7'h00;
      acc_q <= 16'h0000;
      result_high_byte_q <= 8'h00;
      result_low_byte_q <= 8'h00;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          power_q <= enable_bit;
          if (start_ok) begin
            tk_rem_q <= 4'h0;
            sar_rem_q <= tracking_delay_bit ? `TRACK_SAR_TICKS : 3'h0;
            if (burst_bit && !power_q && !enable_bit) begin
              power_q <= 1'b1;
              pw_rem_q <= {1'b0, powerup_delay_field} + 5'h01;
              state_q <= S_PWRUP;
            end else if (burst_bit) begin
              power_q <= 1'b1;
              state_q <= S_TRACK;
            end else if (tracking_delay_bit && !ext_sel) begin
              state_q <= S_TRACK;
            end else begin
              conv_rem_q <= conv_len;
              state_q <= S_CONV;
            end
          end
        end
        // Core is already powered here and settles for the programmed delay
        S_PWRUP: begin
          if (burst_tick) begin
            pw_rem_q <= pw_rem_q - 5'h01;
            if (pw_rem_q == 5'h01)
              state_q <= S_TRACK;
          end
        end
        // Burst tracking ticks first, then the four SAR ticks of the delay bit
        S_TRACK: begin
          if (tk_rem_q != 4'h0) begin
            if (burst_tick)
              tk_rem_q <= tk_rem_q - 4'h1;
          end else if (sar_rem_q != 3'h0) begin
            if (sar_tick)
              sar_rem_q <= sar_rem_q - 3'h1;
          end else begin
            conv_rem_q <= conv_len;
            state_q <= S_CONV;
          end
        end
        S_CONV: begin
          if (sar_tick)
            conv_rem_q <= conv_rem_q - 4'h1;
          if (conv_end) begin
            acc_q <= acc_sum;
            if (last_sample) begin
              sample_cnt_q <= 7'h00;
              result_high_byte_q <= formatted[15:8];
              result_low_byte_q <= formatted[7:0];
              result_valid_q <= 1'b1;
              power_q <= burst_bit ? enable_bit : power_q;
              state_q <= S_IDLE;
            end else begin
              sample_cnt_q <= sample_cnt_q + 7'h01;
              if (burst_bit) begin
                tk_rem_q <= burst_tracking_field;
                sar_rem_q <= tracking_delay_bit ? `TRACK_SAR_TICKS : 3'h0;
                state_q <= S_TRACK;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Continuous tracking when idle in non-burst; pin-gated tracking with delay bit
  wire idle_track = !burst_bit && state_q[0] && !(ext_sel && tracking_delay_bit &&
                    external_convert_pin);
  assign core_power = power_q;
  assign core_track = power_q && (state_q[2] || idle_track);
  assign core_convert = state_q[3];
  assign core_eight_bit = eight_bit_mode_bit;
  assign conversion_complete_flag = done_q;
  assign conversion_busy_bit = !state_q[0];

endmodule // adc_burst_accumulate_control
`default_nettype wire

//--- shared/adc_burst_defines.vh
// Constants for the converter sequencing and result formatting block
`ifndef ADC_BURST_DEFINES_VH
`define ADC_BURST_DEFINES_VH

// Register offsets (byte addresses)
`define OFS_CONTROL 8'h00
`define OFS_CONFIG 8'h04
`define OFS_TIMING 8'h08
`define OFS_RESULT_HIGH 8'h0C
`define OFS_RESULT_LOW 8'h10

// Control register fields
`define CTL_ENABLE 7
`define CTL_BURST 6
`define CTL_DONE 5
`define CTL_BUSY 4
`define CTL_TRIG_HI 1
`define CTL_TRIG_LO 0

// Trigger source encodings
`define TRIG_SOFTWARE 2'h0
`define TRIG_INTERNAL 2'h1
`define TRIG_EXTERNAL 2'h2

// Config register fields
`define CFG_TRACK_DELAY 0
`define CFG_EIGHT_BIT 1
`define CFG_JUST_HI 4
`define CFG_JUST_LO 2
`define CFG_RPT_HI 7
`define CFG_RPT_LO 5

// Timing register fields
`define TIM_PWR_HI 7
`define TIM_PWR_LO 4
`define TIM_TRK_HI 3
`define TIM_TRK_LO 0

// Justification codes
`define JUST_LEFT 3'h4

// Sequencing counts
`define TRACK_SAR_TICKS 3'h4
`define CONV_TICKS_10 4'hC
`define CONV_TICKS_8 4'hA

// Reset values
`define CONTROL_RESET 8'h00
`define CONFIG_RESET 8'h00
`define TIMING_RESET 8'h00

`endif

//--- verification/adc_burst_props.sv
// Port assertions for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adc_burst_defines.vh"
module adc_burst_props #(parameter SAR_DIV = 4, parameter BURST_DIV = 2) (
  // Clock, reset and register port
  input wire clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata_q,
  // Triggers and core
  input wire internal_trigger,
  input wire external_convert_pin,
  input wire [9:0] core_code,
  input wire core_power,
  input wire core_track,
  input wire core_convert,
  input wire core_eight_bit,
  // Results and status
  input wire [7:0] result_high_byte_q,
  input wire [7:0] result_low_byte_q,
  input wire result_valid_q,
  input wire conversion_complete_flag,
  input wire conversion_busy_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_vflag; result_valid_q |-> conversion_complete_flag; endproperty
  a_vflag: assert property (p_vflag) else $error("result without flag");
  property p_vpulse; result_valid_q |=> !result_valid_q; endproperty
  a_vpulse: assert property (p_vpulse) else $error("result pulse too long");
  property p_upd; $changed({result_high_byte_q, result_low_byte_q}) |-> result_valid_q; endproperty
  a_upd: assert property (p_upd) else $error("result moved mid series");
  property p_low8; result_valid_q && core_eight_bit |-> result_low_byte_q == 8'h00; endproperty
  a_low8: assert property (p_low8) else $error("low byte not zero");
  property p_clen; $rose(core_convert) |-> core_convert [*8]; endproperty
  a_clen: assert property (p_clen) else $error("conversion too short");
  property p_busy; core_convert |-> conversion_busy_bit && core_power; endproperty
  a_busy: assert property (p_busy) else $error("converting while idle or off");
  property p_trk; core_convert |-> !core_track; endproperty
  a_trk: assert property (p_trk) else $error("tracking during conversion");
  property p_vend; result_valid_q |-> $past(core_convert) || $past(core_convert, 2); endproperty
  a_vend: assert property (p_vend) else $error("result not after conversion");
  property p_hold;
    conversion_complete_flag && !(reg_write && reg_addr == `OFS_CONTROL && !reg_wdata[5])
      |=> conversion_complete_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  c_eight: cover property (result_valid_q && core_eight_bit);
  c_up: cover property ($rose(core_power));
  c_down: cover property ($fell(core_power));
endmodule // adc_burst_props
`default_nettype wire

//--- verification/adc_core_model.sv
// Behavioural analog converter core
`timescale 1ns/100ps
`default_nettype none
module adc_core_model (
  // Sequencer side
  input wire logic core_convert,
  input wire logic core_eight_bit,
  // Analog level as a code
  input wire logic [9:0] level,
  output logic [9:0] core_code
);
  // Outside a conversion the code is not held, so show the inverse
  assign core_code = !core_convert ? ~level : core_eight_bit ? {level[9:2], 2'b00} : level;
endmodule // adc_core_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adc_burst_defines.vh"
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, reg_write = 1'b0, reg_read = 1'b0, internal_trigger = 1'b0;
  logic external_convert_pin = 1'b0, cprev = 1'b0, clr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
  logic [9:0] level = 10'h000;
  logic [31:0] rnd = 32'h0000AE5A;
  wire [7:0] reg_rdata_q, result_high_byte_q, result_low_byte_q;
  wire [9:0] core_code;
  wire core_power, core_track, core_convert, core_eight_bit, result_valid_q;
  wire conversion_complete_flag, conversion_busy_bit;
  int n_errors = 0, comparisons = 0, n_conv = 0, pre = 0, clen = 0, last_len = 0;
  always #2 clk = ~clk;
  adc_burst_accumulate_control #(.SAR_DIV(1), .BURST_DIV(1)) i_adc_burst_accumulate_control (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
    .internal_trigger(internal_trigger), .external_convert_pin(external_convert_pin),
    .core_code(core_code), .core_power(core_power), .core_track(core_track),
    .core_convert(core_convert), .core_eight_bit(core_eight_bit),
    .result_high_byte_q(result_high_byte_q), .result_low_byte_q(result_low_byte_q),
    .result_valid_q(result_valid_q), .conversion_complete_flag(conversion_complete_flag),
    .conversion_busy_bit(conversion_busy_bit));
  adc_core_model i_adc_core_model (.core_convert(core_convert),
    .core_eight_bit(core_eight_bit), .level(level), .core_code(core_code));
  always @(posedge clk) begin
    cprev <= core_convert;
    clen <= core_convert ? clen + 1 : 0;
    if (cprev && !core_convert) last_len <= clen;
    if (clr) begin
      n_conv <= 0;
      pre <= 0;
    end else begin
      if (core_convert && !cprev) n_conv <= n_conv + 1;
      if (conversion_busy_bit && !core_convert && n_conv == 0) pre <= pre + 1;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] fmt(input logic [15:0] s, input logic [2:0] j, input logic e);
    logic [15:0] f;
    f = j[2] ? {s[9:0], 6'h00} : s >> j[1:0];
    fmt = e ? {f[9:2], 8'h00} : f;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata_q;
  endtask
  task automatic kick(input logic [7:0] ctl);
    if (ctl[1:0] == `TRIG_SOFTWARE) wr(`OFS_CONTROL, ctl | 8'h10);
    else begin
      @(posedge clk);
      internal_trigger <= !ctl[1];
      external_convert_pin <= ctl[1];
      @(posedge clk);
      internal_trigger <= 1'b0;
    end
  endtask
  task automatic series(input logic [7:0] ctl, input logic [7:0] cfg, input int n);
    logic [15:0] s;
    int t;
    rnd = lfsr(rnd);
    s = {6'h00, rnd[9:2], cfg[1] ? 2'b00 : rnd[1:0]};
    s = fmt(16'(s * n), cfg[4:2], cfg[1]);
    @(posedge clk);
    level <= rnd[9:0];
    external_convert_pin <= 1'b0;
    wr(`OFS_CONFIG, cfg);
    wr(`OFS_CONTROL, ctl);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (5) @(posedge clk);
    check(16'(n_conv), 16'h0000);
    kick(ctl);
    if (ctl[6]) begin
      repeat (4) @(posedge clk);
      kick(ctl);
    end
    for (t = 0; t < 4000 && result_valid_q !== 1'b1; t++) @(negedge clk);
    check(16'(t < 4000), 16'h0001);
    check({result_high_byte_q, result_low_byte_q}, s);
    repeat (3) @(negedge clk);
    check(16'(n_conv), 16'(n));
    check(16'(last_len), cfg[1] ? 16'h000A : 16'h000C);
    check({15'h0000, conversion_complete_flag}, 16'h0001);
    check({15'h0000, conversion_busy_bit}, 16'h0000);
    if (ctl[6]) check({15'h0000, core_power}, {15'h0000, ctl[7]});
    else if (!ctl[1]) check(16'(cfg[0] ? pre >= 4 : pre == 0), 16'h0001);
    rd(`OFS_RESULT_HIGH, d);
    check({8'h00, d}, {8'h00, s[15:8]});
    wr(`OFS_CONTROL, 8'h00);
    #1 check({15'h0000, conversion_complete_flag}, 16'h0000);
    $display("series ctl %h cfg %h done", ctl, cfg);
  endtask
  task automatic conclude;
    $display("%0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd(8'(a * 4), d);
      check({8'h00, d}, 16'h0000);
    end
    rnd = lfsr(rnd);
    wr(`OFS_TIMING, rnd[7:0]);
    rd(`OFS_TIMING, d);
    check({8'h00, d}, {8'h00, rnd[7:0]});
    series(8'h80, 8'h00, 1);
    series(8'h80, 8'h10, 1);
    series(8'h80, 8'h02, 1);
    series(8'h80, 8'h01, 1);
    series(8'h81, 8'h01, 1);
    series(8'h82, 8'h01, 1);
    for (int k = 0; k < 6; k++)
      series({k[0], 6'h20, k[1]}, {k[2:0], 1'b0, k[1:0], 1'b0, k[2]}, k == 0 ? 1 : 2 << k);
    series(8'hC0, 8'hE0, 64);
    conclude();
  end
endmodule // testbench
bind adc_burst_accumulate_control adc_burst_props #(.SAR_DIV(SAR_DIV), .BURST_DIV(BURST_DIV))
  i_adc_burst_props (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
  .internal_trigger(internal_trigger), .external_convert_pin(external_convert_pin),
  .core_code(core_code), .core_power(core_power), .core_track(core_track),
  .core_convert(core_convert), .core_eight_bit(core_eight_bit),
  .result_high_byte_q(result_high_byte_q), .result_low_byte_q(result_low_byte_q),
  .result_valid_q(result_valid_q), .conversion_complete_flag(conversion_complete_flag),
  .conversion_busy_bit(conversion_busy_bit));
`default_nettype wire
